// ===== shared/irq_ctrl_pkg.sv
// constants shared by the maskable interrupt controller and its helpers
// assumes one 250 MHz clock and an instruction-cycle enable from the sequencer
package irq_ctrl_pkg;

	// ************************************************************
	// sources and arbitration
	// ************************************************************
	localparam int NUM_SRC = 11;
	localparam int SLOT_W = 4;
	localparam int PC_W = 15;
	localparam int DATA_W = 8;
	localparam int ADDR_W = 8;

	// vector slot per maskable source, index 0 ranks highest
	localparam logic [SLOT_W-1:0] SRC_SLOT [NUM_SRC] = '{
		4'he, 4'hd, 4'hc, 4'hb, 4'ha, 4'h9, 4'h8, 4'h7, 4'h6, 4'h5, 4'h1
	};
	localparam logic [SLOT_W-1:0] TRAP_SLOT = 4'hf;
	localparam logic [SLOT_W-1:0] DEFAULT_SLOT = 4'h0;
	localparam logic [2:0] VECTOR_BASE_HI = 3'h7;

	// ************************************************************
	// addresses and timing
	// ************************************************************
	localparam logic [PC_W-1:0] SERVICE_ADDR = 15'h00ff;
	localparam logic [2:0] ACK_CYCLES = 3'h7;
	localparam int PC_PAGE_LSB = 8;

	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [ADDR_W-1:0] ENABLE_LO_ADDR = 8'h00;
	localparam logic [ADDR_W-1:0] ENABLE_HI_ADDR = 8'h01;
	localparam logic [ADDR_W-1:0] PENDING_LO_ADDR = 8'h02;
	localparam logic [ADDR_W-1:0] PENDING_HI_ADDR = 8'h03;
	localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
	localparam int HI_W = NUM_SRC - DATA_W;
	localparam int STATUS_GLOBAL_EN_BIT = 0;
	localparam int STATUS_TRAP_PEND_BIT = 1;
	localparam int STATUS_TRAP_SERV_BIT = 2;
	localparam int STATUS_BUSY_BIT = 3;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	typedef enum logic [1:0] {ST_IDLE, ST_ACK, ST_POP} ctrl_state_type;

endpackage

// ===== src/irq_pending_bank.sv
// pending flags of the maskable sources
// assumes event pulses come from logic on the same clock
`timescale 1ns/10ps
module irq_pending_bank
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] set_i,
	input wire logic wr_lo_i,
	input wire logic wr_hi_i,
	input wire logic [irq_ctrl_pkg::DATA_W-1:0] wdata_i,
	output logic [irq_ctrl_pkg::NUM_SRC-1:0] pending_o
);
	logic [irq_ctrl_pkg::NUM_SRC-1:0] next_pending;

	always_comb
	begin
		next_pending = pending_o;
		if (wr_lo_i)
		begin
			next_pending[irq_ctrl_pkg::DATA_W-1:0] = wdata_i;
		end
		if (wr_hi_i)
		begin
			next_pending[irq_ctrl_pkg::NUM_SRC-1:irq_ctrl_pkg::DATA_W] =
				wdata_i[irq_ctrl_pkg::HI_W-1:0];
		end
		// an event in the clearing cycle is kept
		next_pending = next_pending | set_i;
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pending_o <= '0;
		end
		else
		begin
			pending_o <= next_pending;
		end
	end
endmodule // irq_pending_bank

// ===== src/irq_arbiter.sv
// fixed-rank arbitration over trap and maskable sources
// purely combinational, read by the controller on the same clock
`timescale 1ns/10ps
module irq_arbiter
(
	input wire logic trap_i,
	input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] active_i,
	output logic any_o,
	output logic [irq_ctrl_pkg::SLOT_W-1:0] slot_o
);
	always_comb
	begin
		any_o = trap_i | (|active_i);
		slot_o = irq_ctrl_pkg::DEFAULT_SLOT;
		// walk from lowest rank upward so the highest rank is written last
		for (int i = irq_ctrl_pkg::NUM_SRC - 1; i >= 0; i--)
		begin
			if (active_i[i])
			begin
				slot_o = irq_ctrl_pkg::SRC_SLOT[i];
			end
		end
		if (trap_i)
		begin
			slot_o = irq_ctrl_pkg::TRAP_SLOT;
		end
	end
endmodule // irq_arbiter

// ===== src/maskable_interrupt_controller.sv
// interrupt controller: enables, pending flags, global enable,
// acknowledgment, return and vector selection for the core sequencer
// assumes the sequencer pulses instr_start_i only for executed instructions
// and cycle_en_i once per instruction cycle, all on clock_i
`timescale 1ns/10ps

module maskable_interrupt_controller
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	// register port
	input wire logic [irq_ctrl_pkg::ADDR_W-1:0] addr_i,
	input wire logic [irq_ctrl_pkg::DATA_W-1:0] wdata_i,
	input wire logic we_i,
	input wire logic re_i,
	output logic [irq_ctrl_pkg::DATA_W-1:0] rdata_o,
	// event sources
	input wire logic [irq_ctrl_pkg::NUM_SRC-1:0] event_i,
	input wire logic soft_trap_i,
	input wire logic clear_trap_i,
	// core sequencer
	input wire logic cycle_en_i,
	input wire logic instr_start_i,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] pc_i,
	input wire logic vector_select_instr_i,
	input wire logic return_from_irq_instr_i,
	input wire logic pop_valid_i,
	input wire logic [irq_ctrl_pkg::PC_W-1:0] pop_data_i,
	output logic ack_busy_o,
	output logic push_o,
	output logic [irq_ctrl_pkg::PC_W-1:0] push_addr_o,
	output logic pop_o,
	output logic pc_load_o,
	output logic [irq_ctrl_pkg::PC_W-1:0] pc_value_o,
	output logic global_irq_enable_o
);

	// ************************************************************
	// declarations
	// ************************************************************
	irq_ctrl_pkg::ctrl_state_type state;
	logic [irq_ctrl_pkg::NUM_SRC-1:0] enable;
	logic [irq_ctrl_pkg::NUM_SRC-1:0] pending;
	logic [irq_ctrl_pkg::NUM_SRC-1:0] active;
	logic global_irq_enable;
	logic trap_pending;
	logic trap_service;
	logic [2:0] ack_count;
	logic trap_wins;
	logic maskable_req;
	logic trap_req;
	logic take_irq;
	logic [irq_ctrl_pkg::SLOT_W-1:0] vector_slot;
	logic wr_enable_lo;
	logic wr_enable_hi;
	logic wr_pending_lo;
	logic wr_pending_hi;
	logic wr_status;
	logic ack_last;
	logic [irq_ctrl_pkg::DATA_W-1:0] next_rdata;
	logic [irq_ctrl_pkg::DATA_W-1:0] status_word;

	// ************************************************************
	// register decode
	// ************************************************************
	assign wr_enable_lo = we_i && (addr_i == irq_ctrl_pkg::ENABLE_LO_ADDR);
	assign wr_enable_hi = we_i && (addr_i == irq_ctrl_pkg::ENABLE_HI_ADDR);
	assign wr_pending_lo = we_i && (addr_i == irq_ctrl_pkg::PENDING_LO_ADDR);
	assign wr_pending_hi = we_i && (addr_i == irq_ctrl_pkg::PENDING_HI_ADDR);
	assign wr_status = we_i && (addr_i == irq_ctrl_pkg::STATUS_ADDR);

	// ************************************************************
	// pending flags and arbitration
	// ************************************************************
	irq_pending_bank pending_bank
	(
		.clock_i(clock_i),
		.arst_n_i(arst_n_i),
		.set_i(event_i),
		.wr_lo_i(wr_pending_lo),
		.wr_hi_i(wr_pending_hi),
		.wdata_i(wdata_i),
		.pending_o(pending)
	);

	assign active = enable & pending;

	irq_arbiter arbiter
	(
		.trap_i(trap_pending),
		.active_i(active),
		.any_o(),
		.slot_o(vector_slot)
	);

	// ************************************************************
	// trigger qualification
	// ************************************************************
	// a trap being serviced holds every maskable request off
	assign maskable_req = (|active) && global_irq_enable && !trap_service;
	assign trap_req = trap_pending && !trap_service;
	assign trap_wins = trap_req;
	// no latching of requests: a freshly enabled pending bit counts at once
	assign take_irq = (state == irq_ctrl_pkg::ST_IDLE) && instr_start_i
		&& (maskable_req || trap_req);
	assign ack_last = (state == irq_ctrl_pkg::ST_ACK) && cycle_en_i
		&& (ack_count == irq_ctrl_pkg::ACK_CYCLES - 3'h1);

	// ************************************************************
	// enable bits
	// ************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			enable <= '0;
		end
		else
		begin
			if (wr_enable_lo)
			begin
				enable[irq_ctrl_pkg::DATA_W-1:0] <= wdata_i;
			end
			if (wr_enable_hi)
			begin
				enable[irq_ctrl_pkg::NUM_SRC-1:irq_ctrl_pkg::DATA_W] <=
					wdata_i[irq_ctrl_pkg::HI_W-1:0];
			end
		end
	end

	// ************************************************************
	// global enable
	// ************************************************************
	// acknowledgment wins over a software write in the same cycle so a
	// service routine never starts with the enable left on
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			global_irq_enable <= 1'b0;
		end
		else if (take_irq)
		begin
			global_irq_enable <= 1'b0;
		end
		else if (return_from_irq_instr_i && state == irq_ctrl_pkg::ST_IDLE)
		begin
			global_irq_enable <= 1'b1;
		end
		else if (wr_status)
		begin
			global_irq_enable <= wdata_i[irq_ctrl_pkg::STATUS_GLOBAL_EN_BIT];
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			global_irq_enable_o <= 1'b0;
		end
		else
		begin
			global_irq_enable_o <= global_irq_enable;
		end
	end

	// ************************************************************
	// software trap
	// ************************************************************
	// the trap is not maskable; only its own clear instruction ends it
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			trap_pending <= 1'b0;
		end
		else if (soft_trap_i)
		begin
			trap_pending <= 1'b1;
		end
		else if (clear_trap_i)
		begin
			trap_pending <= 1'b0;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			trap_service <= 1'b0;
		end
		else if (take_irq && trap_wins)
		begin
			trap_service <= 1'b1;
		end
		else if (clear_trap_i)
		begin
			trap_service <= 1'b0;
		end
	end

	// ************************************************************
	// sequence control
	// ************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state <= irq_ctrl_pkg::ST_IDLE;
		end
		else
		begin
			case (state)
				irq_ctrl_pkg::ST_IDLE:
				begin
					if (take_irq)
					begin
						state <= irq_ctrl_pkg::ST_ACK;
					end
					else if (return_from_irq_instr_i)
					begin
						state <= irq_ctrl_pkg::ST_POP;
					end
				end
				irq_ctrl_pkg::ST_ACK:
				begin
					if (ack_last)
					begin
						state <= irq_ctrl_pkg::ST_IDLE;
					end
				end
				irq_ctrl_pkg::ST_POP:
				begin
					if (pop_valid_i)
					begin
						state <= irq_ctrl_pkg::ST_IDLE;
					end
				end
				default:
				begin
					state <= irq_ctrl_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_count <= 3'h0;
		end
		else if (take_irq)
		begin
			ack_count <= 3'h0;
		end
		else if (state == irq_ctrl_pkg::ST_ACK && cycle_en_i)
		begin
			ack_count <= ack_count + 3'h1;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ack_busy_o <= 1'b0;
		end
		else if (take_irq)
		begin
			ack_busy_o <= 1'b1;
		end
		else if (ack_last)
		begin
			ack_busy_o <= 1'b0;
		end
	end

	// ************************************************************
	// stack traffic
	// ************************************************************
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			push_o <= 1'b0;
			push_addr_o <= '0;
		end
		else
		begin
			push_o <= take_irq;
			if (take_irq)
			begin
				push_addr_o <= pc_i;
			end
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pop_o <= 1'b0;
		end
		else
		begin
			pop_o <= return_from_irq_instr_i && (state == irq_ctrl_pkg::ST_IDLE)
				&& !take_irq;
		end
	end

	// ************************************************************
	// program counter loads
	// ************************************************************
	// the vector slot becomes an even low byte; the vector word itself
	// is fetched high byte first by the core
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			pc_load_o <= 1'b0;
			pc_value_o <= '0;
		end
		else
		begin
			pc_load_o <= 1'b0;
			if (ack_last)
			begin
				pc_load_o <= 1'b1;
				pc_value_o <= irq_ctrl_pkg::SERVICE_ADDR;
			end
			else if (state == irq_ctrl_pkg::ST_POP && pop_valid_i)
			begin
				pc_load_o <= 1'b1;
				pc_value_o <= pop_data_i;
			end
			else if (vector_select_instr_i && state == irq_ctrl_pkg::ST_IDLE)
			begin
				pc_load_o <= 1'b1;
				pc_value_o <= {pc_i[irq_ctrl_pkg::PC_W-1:irq_ctrl_pkg::PC_PAGE_LSB],
					irq_ctrl_pkg::VECTOR_BASE_HI, vector_slot, 1'b0};
			end
		end
	end

	// ************************************************************
	// register read
	// ************************************************************
	always_comb
	begin
		status_word = irq_ctrl_pkg::READ_ZERO;
		status_word[irq_ctrl_pkg::STATUS_GLOBAL_EN_BIT] = global_irq_enable;
		status_word[irq_ctrl_pkg::STATUS_TRAP_PEND_BIT] = trap_pending;
		status_word[irq_ctrl_pkg::STATUS_TRAP_SERV_BIT] = trap_service;
		status_word[irq_ctrl_pkg::STATUS_BUSY_BIT] = ack_busy_o;
	end

	always_comb
	begin
		next_rdata = irq_ctrl_pkg::READ_ZERO;
		if (re_i)
		begin
			case (addr_i)
				irq_ctrl_pkg::ENABLE_LO_ADDR:
				begin
					next_rdata = enable[irq_ctrl_pkg::DATA_W-1:0];
				end
				irq_ctrl_pkg::ENABLE_HI_ADDR:
				begin
					next_rdata[irq_ctrl_pkg::HI_W-1:0] =
						enable[irq_ctrl_pkg::NUM_SRC-1:irq_ctrl_pkg::DATA_W];
				end
				irq_ctrl_pkg::PENDING_LO_ADDR:
				begin
					next_rdata = pending[irq_ctrl_pkg::DATA_W-1:0];
				end
				irq_ctrl_pkg::PENDING_HI_ADDR:
				begin
					next_rdata[irq_ctrl_pkg::HI_W-1:0] =
						pending[irq_ctrl_pkg::NUM_SRC-1:irq_ctrl_pkg::DATA_W];
				end
				irq_ctrl_pkg::STATUS_ADDR:
				begin
					next_rdata = status_word;
				end
				default:
				begin
					next_rdata = irq_ctrl_pkg::READ_ZERO;
				end
			endcase
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			rdata_o <= irq_ctrl_pkg::READ_ZERO;
		end
		else
		begin
			rdata_o <= next_rdata;
		end
	end

endmodule // maskable_interrupt_controller

// ===== tb/core_seq_model.sv
// sequencer and stack model beside the interrupt controller
// assumes the controller pushes and pops on clock_i with one-cycle pulses
`timescale 1ns/10ps
module core_seq_model
#(
	parameter int EN_GAP = 3,
	parameter int POP_WAIT = 2
)
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic push_i,
	input wire logic [14:0] push_addr_i,
	input wire logic pop_i,
	output logic cycle_en_o,
	output logic pop_valid_o,
	output logic [14:0] pop_data_o
);
	// ************************************************************
	// instruction cycles and stack
	// ************************************************************
	logic [14:0] stack [4];
	logic [1:0] sp;
	int gap;
	int wait_cnt;
	logic popping;

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			gap <= 0;
			cycle_en_o <= 1'b0;
		end
		else
		begin
			cycle_en_o <= (gap == 0);
			gap <= (gap == EN_GAP - 1) ? 0 : gap + 1;
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sp <= 2'h0;
			popping <= 1'b0;
			wait_cnt <= 0;
			pop_valid_o <= 1'b0;
			pop_data_o <= 15'h0000;
		end
		else
		begin
			pop_valid_o <= 1'b0;
			if (push_i)
			begin
				stack[sp] <= push_addr_i;
				sp <= sp + 2'h1;
			end
			if (pop_i)
			begin
				popping <= 1'b1;
				wait_cnt <= POP_WAIT;
			end
			else if (popping && wait_cnt == 0)
			begin
				popping <= 1'b0;
				pop_valid_o <= 1'b1;
				pop_data_o <= stack[sp - 2'h1];
				sp <= sp - 2'h1;
			end
			else
			begin
				wait_cnt <= wait_cnt - 1;
				// stale data must never look valid
				pop_data_o <= ~pop_data_o;
			end
		end
	end
endmodule // core_seq_model

// ===== tb/irq_ctrl_chk.sv
// timing checks on the interrupt controller ports
// assumes one clock domain and the sequencer model's pulse spacing
`timescale 1ns/10ps
module irq_ctrl_chk
(
	input wire logic clock_i,
	input wire logic arst_n_i,
	input wire logic re_i,
	input wire logic [7:0] rdata_o,
	input wire logic instr_start_i,
	input wire logic [14:0] pc_i,
	input wire logic vector_select_instr_i,
	input wire logic return_from_irq_instr_i,
	input wire logic cycle_en_i,
	input wire logic pop_valid_i,
	input wire logic [14:0] pop_data_i,
	input wire logic ack_busy_o,
	input wire logic push_o,
	input wire logic [14:0] push_addr_o,
	input wire logic pop_o,
	input wire logic pc_load_o,
	input wire logic [14:0] pc_value_o,
	input wire logic global_irq_enable_o
);
	// ************************************************************
	// helpers and properties
	// ************************************************************
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	logic [3:0] en_cnt;
	logic [6:0] pc_hi;

	always_ff @(posedge clock_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			en_cnt <= 4'h0;
		else if (!ack_busy_o)
			en_cnt <= 4'h0;
		else if (cycle_en_i)
			en_cnt <= en_cnt + 4'h1;
	end

	always_ff @(posedge clock_i)
		pc_hi <= pc_i[14:8];

	sequence s_take;
		!ack_busy_o ##1 ack_busy_o && push_o;
	endsequence
	sequence s_jump;
		pc_load_o && pc_value_o == 15'h00ff;
	endsequence

	property p_take_cause;
		$rose(ack_busy_o) |-> $past(instr_start_i);
	endproperty
	property p_push;
		s_take |-> push_addr_o == $past(pc_i);
	endproperty
	property p_enable_clear;
		$rose(ack_busy_o) |=> !global_irq_enable_o;
	endproperty
	property p_jump;
		$fell(ack_busy_o) |-> s_jump;
	endproperty
	property p_seven;
		$fell(ack_busy_o) |-> en_cnt == 4'h7;
	endproperty
	property p_rdata_idle;
		!$past(re_i) |-> rdata_o == 8'h00;
	endproperty
	property p_vector;
		vector_select_instr_i && !ack_busy_o |=> pc_load_o && pc_value_o[14:8] == pc_hi
			&& pc_value_o[7:5] == 3'h7 && !pc_value_o[0];
	endproperty
	property p_ret;
		return_from_irq_instr_i && !ack_busy_o && !instr_start_i |=> pop_o ##1 global_irq_enable_o;
	endproperty
	property p_pop_load;
		pop_valid_i |=> pc_load_o && pc_value_o == $past(pop_data_i);
	endproperty

	a_take_cause: assert property (p_take_cause) else $error("take without start");
	a_push: assert property (p_push) else $error("wrong pushed address");
	a_enable_clear: assert property (p_enable_clear) else $error("enable kept on take");
	a_jump: assert property (p_jump) else $error("no jump to service");
	a_seven: assert property (p_seven) else $error("take length wrong");
	a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
	a_vector: assert property (p_vector) else $error("bad vector address");
	a_ret: assert property (p_ret) else $error("return not done");
	a_pop_load: assert property (p_pop_load) else $error("pop not loaded");
endmodule // irq_ctrl_chk

bind maskable_interrupt_controller irq_ctrl_chk u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i),
	.re_i(re_i), .rdata_o(rdata_o), .instr_start_i(instr_start_i), .pc_i(pc_i),
	.vector_select_instr_i(vector_select_instr_i), .cycle_en_i(cycle_en_i),
	.return_from_irq_instr_i(return_from_irq_instr_i), .pop_valid_i(pop_valid_i),
	.pop_data_i(pop_data_i), .ack_busy_o(ack_busy_o), .push_o(push_o),
	.push_addr_o(push_addr_o), .pop_o(pop_o), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
	.global_irq_enable_o(global_irq_enable_o));

// ===== tb/maskable_interrupt_controller_tb.sv
// self-checking bench for the interrupt controller
// assumes the sequencer model supplies cycle enables and stack pops
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
	$display("wrong value at %0t: compare failed", $time); end end
module maskable_interrupt_controller_tb;
	// ************************************************************
	// stimulus
	// ************************************************************
	logic clock_i = 0, arst_n_i = 0, we_i = 0, re_i = 0, instr_start_i = 0;
	logic soft_trap_i = 0, clear_trap_i = 0, vsel_i = 0, ret_i = 0;
	logic [7:0] addr_i = 8'h00, wdata_i = 8'h00, rdata_o;
	logic [10:0] event_i = 11'h000;
	logic [14:0] pc_i = 15'h0000, push_addr_o, pc_value_o, pop_data;
	logic cycle_en, pop_valid, ack_busy_o, push_o, pop_o, pc_load_o, irq_en;
	logic [7:0] vec [11] = '{8'hfc, 8'hfa, 8'hf8, 8'hf6, 8'hf4, 8'hf2, 8'hf0, 8'hee, 8'hec,
		8'hea, 8'he2};
	int fail_count = 0, checked = 0;

	maskable_interrupt_controller dut (.clock_i(clock_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o), .event_i(event_i),
		.soft_trap_i(soft_trap_i), .clear_trap_i(clear_trap_i), .cycle_en_i(cycle_en),
		.instr_start_i(instr_start_i), .pc_i(pc_i), .vector_select_instr_i(vsel_i),
		.return_from_irq_instr_i(ret_i), .pop_valid_i(pop_valid), .pop_data_i(pop_data),
		.ack_busy_o(ack_busy_o), .push_o(push_o), .push_addr_o(push_addr_o), .pop_o(pop_o),
		.pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .global_irq_enable_o(irq_en));
	core_seq_model seq (.clock_i(clock_i), .arst_n_i(arst_n_i), .push_i(push_o),
		.push_addr_i(push_addr_o), .pop_i(pop_o), .cycle_en_o(cycle_en),
		.pop_valid_o(pop_valid), .pop_data_o(pop_data));

	initial
	begin
		forever #2 clock_i = ~clock_i;
	end

	task automatic print_verdict();
		$display("compares %0d, mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// tasks start right after a rising edge and return right after one
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		we_i <= 1'b1; addr_i <= a; wdata_i <= d;
		@(posedge clock_i) we_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		re_i <= 1'b1; addr_i <= a;
		@(posedge clock_i) re_i <= 1'b0;
		@(negedge clock_i) `CHK(rdata_o, exp)
		@(posedge clock_i);
	endtask
	task automatic instr(input logic [14:0] pc, input logic exp);
		instr_start_i <= 1'b1; pc_i <= pc;
		@(posedge clock_i) instr_start_i <= 1'b0;
		@(negedge clock_i) `CHK(push_o, exp)
		if (exp) `CHK(push_addr_o, pc)
		@(posedge clock_i);
	endtask
	task automatic wait_load(input logic [14:0] exp);
		int k;
		// look only at falling edges, where a load launched on a rising edge has settled
		for (k = 0; k < 40; k++)
		begin
			@(negedge clock_i);
			if (pc_load_o === 1'b1)
				break;
		end
		if (k == 40)
		begin
			fail_count++;
			print_verdict();
		end
		else
		begin
			`CHK(pc_value_o, exp)
			@(posedge clock_i);
		end
	endtask
	task automatic vector_sel(input logic [14:0] exp);
		vsel_i <= 1'b1; pc_i <= 15'h0155;
		@(posedge clock_i) vsel_i <= 1'b0;
		@(negedge clock_i) `CHK(pc_value_o, exp)
		@(posedge clock_i);
	endtask
	task automatic pulse_ret();
		ret_i <= 1'b1;
		@(posedge clock_i) ret_i <= 1'b0;
	endtask

	initial
	begin
		repeat (3) @(posedge clock_i);
		arst_n_i <= 1'b1;
		@(posedge clock_i);
		for (int a = 0; a < 6; a++) rd(8'(a), 8'h00);
		event_i <= 11'h008;
		@(posedge clock_i) event_i <= 11'h000;
		rd(irq_ctrl_pkg::PENDING_LO_ADDR, 8'h08);
		wr(irq_ctrl_pkg::ENABLE_LO_ADDR, 8'h08);
		instr(15'h1111, 1'b0);
		wr(irq_ctrl_pkg::STATUS_ADDR, 8'h01);
		instr(15'h1234, 1'b1);
		wait_load(15'h00ff);
		rd(irq_ctrl_pkg::STATUS_ADDR, 8'h00);
		wr(irq_ctrl_pkg::STATUS_ADDR, 8'h01);
		rd(irq_ctrl_pkg::STATUS_ADDR, 8'h01);
		wr(irq_ctrl_pkg::STATUS_ADDR, 8'h00);
		pulse_ret();
		wait_load(15'h1234);
		rd(irq_ctrl_pkg::STATUS_ADDR, 8'h01);
		`CHK(irq_en, 1'b1)
		instr(15'h1300, 1'b1);
		wait_load(15'h00ff);
		event_i <= 11'h001;
		wr(irq_ctrl_pkg::PENDING_LO_ADDR, 8'h00);
		event_i <= 11'h000;
		rd(irq_ctrl_pkg::PENDING_LO_ADDR, 8'h01);
		wr(irq_ctrl_pkg::PENDING_LO_ADDR, 8'h00);
		pulse_ret();
		wait_load(15'h1300);
		wr(irq_ctrl_pkg::ENABLE_LO_ADDR, 8'hff);
		@(posedge clock_i);
		wr(irq_ctrl_pkg::ENABLE_HI_ADDR, 8'h07);
		rd(irq_ctrl_pkg::ENABLE_HI_ADDR, 8'h07);
		for (int i = 0; i < 11; i++)
		begin
			// lowest maskable source always rides along to prove ranking
			event_i <= 11'h400 | (11'h001 << i);
			@(posedge clock_i) event_i <= 11'h000;
			vector_sel({7'h01, vec[i]});
			wr(irq_ctrl_pkg::PENDING_LO_ADDR, 8'h00);
			@(posedge clock_i);
			wr(irq_ctrl_pkg::PENDING_HI_ADDR, 8'h00);
		end
		vector_sel(15'h01e0);
		wr(irq_ctrl_pkg::STATUS_ADDR, 8'h00);
		soft_trap_i <= 1'b1; event_i <= 11'h001;
		@(posedge clock_i) soft_trap_i <= 1'b0;
		event_i <= 11'h000;
		vector_sel(15'h01fe);
		rd(irq_ctrl_pkg::STATUS_ADDR, 8'h02);
		instr(15'h2000, 1'b1);
		wait_load(15'h00ff);
		rd(irq_ctrl_pkg::STATUS_ADDR, 8'h06);
		pulse_ret();
		wait_load(15'h2000);
		instr(15'h2002, 1'b0);
		clear_trap_i <= 1'b1;
		@(posedge clock_i) clear_trap_i <= 1'b0;
		instr(15'h2004, 1'b1);
		wait_load(15'h00ff);
		print_verdict();
	end
endmodule // maskable_interrupt_controller_tb
